// ===== core/capdesc_byte_mux.sv
`timescale 1ns/100ps
module capdesc_byte_mux
    import capdesc_pkg::*;
#(
    parameter logic [7:0] DESC_TYPE = 8'h10,
    parameter logic [7:0] CAP_CID = 8'h04,
    parameter logic [7:0] CAP_PLAT = 8'h05,
    parameter logic [7:0] CAP_SSP = 8'h0A
) (
    // Descriptor contents
    input wire desc_fields_s fields_i,
    input wire desc_sel_e sel_i,
    input wire logic [5:0] idx_i,
    // Byte and length
    output logic [7:0] byte_o,
    output logic [7:0] len_o
);

    logic [3:0] uoff;
    logic [2:0] doff;
    logic [3:0] soff;
    logic [31:0] attr_word;
    logic [15:0] func_word;

    // Offsets into the multi-byte fields
    assign uoff = 4'(idx_i - IDX_UUID);
    assign doff = 3'(idx_i - IDX_PLAT_DATA);
    assign soff = 4'(idx_i - IDX_SUBLINK);
    // Upper attribute bits are reserved and sent as zero
    assign attr_word = {23'h000000, fields_i.ssic, fields_i.ssac};
    // Full function is promised from this minimum upward; bits 7:4 stay zero
    assign func_word = {fields_i.min_tx, fields_i.min_rx, 4'h0, fields_i.min_ssid};

    // Length follows what is really streamed, variable parts included
    always_comb begin
        unique case (sel_i)
            SEL_CID: len_o = CID_LEN;
            SEL_PLAT: len_o = PLAT_BASE_LEN + {4'h0, fields_i.plat_dlen};
            SEL_SSP: len_o = SSP_BASE_LEN + {1'b0, fields_i.ssac, 2'b00} + 8'h04;
            SEL_NONE: len_o = 8'h00;
        endcase
    end

    // Byte selection; past the length reads zero, except the type byte at offset 1
    always_comb begin
        byte_o = 8'h00;
        if (idx_i == IDX_LEN) begin
            byte_o = len_o;
        end else if (idx_i == IDX_TYPE) begin
            byte_o = DESC_TYPE;
        end else if (idx_i == IDX_CAP) begin
            unique case (sel_i)
                SEL_CID: byte_o = CAP_CID;
                SEL_PLAT: byte_o = CAP_PLAT;
                SEL_SSP: byte_o = CAP_SSP;
                SEL_NONE: byte_o = 8'h00;
            endcase
        end else if (idx_i == IDX_RESV) begin
            byte_o = 8'h00;
        end else if ({2'b00, idx_i} < len_o) begin
            unique case (sel_i)
                SEL_CID: byte_o = fields_i.cid_uuid[uoff*8 +: 8];
                SEL_PLAT: begin
                    if (idx_i < IDX_PLAT_DATA) begin
                        byte_o = fields_i.plat_uuid[uoff*8 +: 8];
                    end else begin
                        byte_o = fields_i.plat_data[doff*8 +: 8];
                    end
                end
                SEL_SSP: begin
                    if (idx_i < IDX_SSP_FUNC) begin
                        byte_o = attr_word[idx_i[1:0]*8 +: 8];
                    end else if (idx_i < IDX_SSP_RESV) begin
                        byte_o = func_word[idx_i[0]*8 +: 8];
                    end else if (idx_i < IDX_SUBLINK) begin
                        byte_o = 8'h00;
                    end else begin
                        byte_o = fields_i.sublink[soff*8 +: 8];
                    end
                end
                SEL_NONE: byte_o = 8'h00;
            endcase
        end
    end

endmodule

// ===== core/capdesc_pkg.sv
package capdesc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SSP_ATTR = 8'h08;
    localparam logic [7:0] OFS_SSP_FUNC = 8'h0C;
    localparam logic [7:0] OFS_PLAT_DLEN = 8'h10;
    localparam logic [7:0] OFS_CID_UUID = 8'h20;
    localparam logic [7:0] OFS_PLAT_UUID = 8'h30;
    localparam logic [7:0] OFS_PLAT_DATA = 8'h40;
    localparam logic [7:0] OFS_SUBLINK = 8'h50;

    // Control register field positions
    localparam int CTRL_HUB_BIT = 0;
    localparam int CTRL_CID_EN_BIT = 1;
    localparam int CTRL_PLAT_EN_BIT = 2;
    localparam int CTRL_SSP_EN_BIT = 3;
    localparam int CTRL_LOCK_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Status register field positions
    localparam int STAT_CID_LEN_LSB = 0;
    localparam int STAT_PLAT_LEN_LSB = 8;
    localparam int STAT_SSP_LEN_LSB = 16;
    localparam int STAT_LOCK_BIT = 24;
    localparam int STAT_PRESENT_LSB = 25;

    // SuperSpeedPlus field positions
    localparam int ATTR_SSAC_LSB = 0;
    localparam int ATTR_SSIC_LSB = 5;
    localparam int FUNC_SSID_LSB = 0;
    localparam int FUNC_RX_LSB = 8;
    localparam int FUNC_TX_LSB = 12;
    localparam int SUBLINK_ID_W = 4;

    // Descriptor geometry
    localparam logic [7:0] CID_LEN = 8'h14;
    localparam logic [7:0] PLAT_BASE_LEN = 8'h14;
    localparam logic [7:0] SSP_BASE_LEN = 8'h0C;
    localparam logic [5:0] IDX_LEN = 6'h00;
    localparam logic [5:0] IDX_TYPE = 6'h01;
    localparam logic [5:0] IDX_CAP = 6'h02;
    localparam logic [5:0] IDX_RESV = 6'h03;
    localparam logic [5:0] IDX_UUID = 6'h04;
    localparam logic [5:0] IDX_PLAT_DATA = 6'h14;
    localparam logic [5:0] IDX_SSP_ATTR = 6'h04;
    localparam logic [5:0] IDX_SSP_FUNC = 6'h08;
    localparam logic [5:0] IDX_SSP_RESV = 6'h0A;
    localparam logic [5:0] IDX_SUBLINK = 6'h0C;
    localparam int PLAT_DATA_MAX = 8;
    localparam int SUBLINK_MAX = 4;
    localparam logic [4:0] SSAC_MAX = 5'h03;
    localparam logic [3:0] DLEN_MAX = 4'h8;

    typedef enum logic [1:0] {
        SEL_CID,
        SEL_PLAT,
        SEL_SSP,
        SEL_NONE
    } desc_sel_e;

    // All software-held descriptor contents
    typedef struct packed {
        logic [127:0] cid_uuid;
        logic [127:0] plat_uuid;
        logic [63:0] plat_data;
        logic [3:0] plat_dlen;
        logic [4:0] ssac;
        logic [3:0] ssic;
        logic [3:0] min_ssid;
        logic [3:0] min_rx;
        logic [3:0] min_tx;
        logic [127:0] sublink;
    } desc_fields_s;

    // One fetch request from the request handler
    typedef struct packed {
        logic req;
        desc_sel_e sel;
        logic [5:0] idx;
        logic direct;
    } fetch_req_s;

endpackage

// ===== core/capdesc_rom.sv
`timescale 1ns/100ps
// Operation
// - A hub always offers the Container ID descriptor; others may omit it.
// - Container ID offered in one operating mode is offered in all modes.
// - Container ID and SuperSpeedPlus are refused on direct standalone requests.
// - Container ID: length, type, capability, reserved, then 16-byte UUID at 4.
// - Container UUID is per-instance and identical across all modes.
// - Reserved byte at offset 3 is zero in all three descriptors.
// - Platform descriptor holds a 16-byte capability UUID at offset 4.
// - Platform descriptor appends zero or more data bytes from offset 20.
// - SuperSpeedPlus descriptor present on capable devices, its type in byte 2.
// - Attribute bits 4:0 hold entry count minus one; bits 31:9 reserved.
// - Attribute bits 8:5 hold speed identifier count minus one.
// - Functionality: min lane speed 3:0, reserved 7:4, rx 11:8, tx 15:12.
// - Full function is reported at every bandwidth at or above the minimum.
// - Reserved word at offset 10 and functionality bits 7:4 are zero.
// - Sublink speed entries are 4-byte words from offset 12, ID in low bits.
module capdesc_rom
    import capdesc_pkg::*;
#(
    // Arbitrary default values, set to the ones the system defines
    parameter logic [7:0] DESC_TYPE = 8'h10,
    parameter logic [7:0] CAP_CID = 8'h04,
    parameter logic [7:0] CAP_PLAT = 8'h05,
    parameter logic [7:0] CAP_SSP = 8'h0A
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // Descriptor fetch port
    input wire fetch_req_s FETCH_I,
    output logic FETCH_VALID_O,
    output logic FETCH_MISS_O,
    output logic FETCH_LAST_O,
    output logic [7:0] FETCH_BYTE_O
);

    logic [4:0] ctrl_reg;
    logic [127:0] cid_uuid_reg;
    logic [127:0] plat_uuid_reg;
    logic [63:0] plat_data_reg;
    logic [3:0] plat_dlen_reg;
    logic [4:0] ssac_reg;
    logic [3:0] ssic_reg;
    logic [3:0] min_ssid_reg;
    logic [3:0] min_rx_reg;
    logic [3:0] min_tx_reg;
    logic [127:0] sublink_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic valid_reg;
    logic miss_reg;
    logic last_reg;
    logic [7:0] byte_reg;
    logic locked;
    logic cid_present;
    logic plat_present;
    logic ssp_present;
    logic sel_present;
    logic refuse;
    logic [7:0] mux_byte;
    logic [7:0] mux_len;
    logic [7:0] len_cid;
    logic [7:0] len_plat;
    logic [7:0] len_ssp;
    logic [4:0] ssac_w;
    logic [3:0] dlen_w;
    desc_fields_s fields;

    assign locked = ctrl_reg[CTRL_LOCK_BIT];
    // Presence depends on no mode input, so an offered descriptor stays offered
    assign cid_present = ctrl_reg[CTRL_HUB_BIT] | ctrl_reg[CTRL_CID_EN_BIT];
    assign plat_present = ctrl_reg[CTRL_PLAT_EN_BIT];
    assign ssp_present = ctrl_reg[CTRL_SSP_EN_BIT];
    // Clamp counts so the stored fields never outgrow the storage behind them
    assign ssac_w = (REG_WDATA_I[ATTR_SSAC_LSB +: 5] > SSAC_MAX) ?
        SSAC_MAX : REG_WDATA_I[ATTR_SSAC_LSB +: 5];
    assign dlen_w = (REG_WDATA_I[3:0] > DLEN_MAX) ? DLEN_MAX : REG_WDATA_I[3:0];

    // Control; lock is sticky and freezes the container identity
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_reg <= CTRL_RESET;
        end else if (REG_WR_I && REG_ADDR_I == OFS_CTRL) begin
            if (locked) begin
                ctrl_reg[CTRL_PLAT_EN_BIT] <= REG_WDATA_I[CTRL_PLAT_EN_BIT];
                ctrl_reg[CTRL_SSP_EN_BIT] <= REG_WDATA_I[CTRL_SSP_EN_BIT];
            end else begin
                ctrl_reg <= REG_WDATA_I[4:0];
            end
        end
    end

    // Container UUID words; frozen once locked so every mode sees one value
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cid_uuid_reg <= 128'h0;
        end else if (REG_WR_I && !locked && REG_ADDR_I[7:4] == OFS_CID_UUID[7:4]) begin
            cid_uuid_reg[REG_ADDR_I[3:2]*32 +: 32] <= REG_WDATA_I;
        end
    end

    // Platform UUID and capability data
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            plat_uuid_reg <= 128'h0;
            plat_data_reg <= 64'h0;
            plat_dlen_reg <= 4'h0;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I[7:4] == OFS_PLAT_UUID[7:4]) begin
                plat_uuid_reg[REG_ADDR_I[3:2]*32 +: 32] <= REG_WDATA_I;
            end else if (REG_ADDR_I[7:3] == OFS_PLAT_DATA[7:3]) begin
                plat_data_reg[REG_ADDR_I[2]*32 +: 32] <= REG_WDATA_I;
            end else if (REG_ADDR_I == OFS_PLAT_DLEN) begin
                plat_dlen_reg <= dlen_w;
            end
        end
    end

    // SuperSpeedPlus counts, minimum functionality and sublink entries
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ssac_reg <= 5'h00;
            ssic_reg <= 4'h0;
            min_ssid_reg <= 4'h0;
            min_rx_reg <= 4'h0;
            min_tx_reg <= 4'h0;
            sublink_reg <= 128'h0;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == OFS_SSP_ATTR) begin
                ssac_reg <= ssac_w;
                ssic_reg <= REG_WDATA_I[ATTR_SSIC_LSB +: 4];
            end else if (REG_ADDR_I == OFS_SSP_FUNC) begin
                min_ssid_reg <= REG_WDATA_I[FUNC_SSID_LSB +: 4];
                min_rx_reg <= REG_WDATA_I[FUNC_RX_LSB +: 4];
                min_tx_reg <= REG_WDATA_I[FUNC_TX_LSB +: 4];
            end else if (REG_ADDR_I[7:4] == OFS_SUBLINK[7:4]) begin
                sublink_reg[REG_ADDR_I[3:2]*32 +: 32] <= REG_WDATA_I;
            end
        end
    end

    assign fields = '{
        cid_uuid: cid_uuid_reg,
        plat_uuid: plat_uuid_reg,
        plat_data: plat_data_reg,
        plat_dlen: plat_dlen_reg,
        ssac: ssac_reg,
        ssic: ssic_reg,
        min_ssid: min_ssid_reg,
        min_rx: min_rx_reg,
        min_tx: min_tx_reg,
        sublink: sublink_reg
    };

    // Lengths for status, same formula as the streamed bytes
    assign len_cid = CID_LEN;
    assign len_plat = PLAT_BASE_LEN + {4'h0, plat_dlen_reg};
    assign len_ssp = SSP_BASE_LEN + {1'b0, ssac_reg, 2'b00} + 8'h04;

    // Read decode; unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0;
        if (REG_ADDR_I == OFS_CTRL) begin
            rdata_next = {27'h0, ctrl_reg};
        end else if (REG_ADDR_I == OFS_STATUS) begin
            rdata_next[STAT_CID_LEN_LSB +: 8] = cid_present ? len_cid : 8'h00;
            rdata_next[STAT_PLAT_LEN_LSB +: 8] = plat_present ? len_plat : 8'h00;
            rdata_next[STAT_SSP_LEN_LSB +: 8] = ssp_present ? len_ssp : 8'h00;
            rdata_next[STAT_LOCK_BIT] = locked;
            rdata_next[STAT_PRESENT_LSB +: 3] = {ssp_present, plat_present, cid_present};
        end else if (REG_ADDR_I == OFS_SSP_ATTR) begin
            rdata_next = {23'h0, ssic_reg, ssac_reg};
        end else if (REG_ADDR_I == OFS_SSP_FUNC) begin
            rdata_next = {16'h0, min_tx_reg, min_rx_reg, 4'h0, min_ssid_reg};
        end else if (REG_ADDR_I == OFS_PLAT_DLEN) begin
            rdata_next = {28'h0, plat_dlen_reg};
        end else if (REG_ADDR_I[7:4] == OFS_CID_UUID[7:4]) begin
            rdata_next = cid_uuid_reg[REG_ADDR_I[3:2]*32 +: 32];
        end else if (REG_ADDR_I[7:4] == OFS_PLAT_UUID[7:4]) begin
            rdata_next = plat_uuid_reg[REG_ADDR_I[3:2]*32 +: 32];
        end else if (REG_ADDR_I[7:3] == OFS_PLAT_DATA[7:3]) begin
            rdata_next = plat_data_reg[REG_ADDR_I[2]*32 +: 32];
        end else if (REG_ADDR_I[7:4] == OFS_SUBLINK[7:4]) begin
            rdata_next = sublink_reg[REG_ADDR_I[3:2]*32 +: 32];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= REG_RD_I ? rdata_next : 32'h0;
        end
    end
    assign REG_RDATA_O = rdata_reg;

    capdesc_byte_mux #(
        .DESC_TYPE(DESC_TYPE),
        .CAP_CID(CAP_CID),
        .CAP_PLAT(CAP_PLAT),
        .CAP_SSP(CAP_SSP)
    ) u_mux (
        .fields_i(fields),
        .sel_i(FETCH_I.sel),
        .idx_i(FETCH_I.idx),
        .byte_o(mux_byte),
        .len_o(mux_len)
    );

    // Refusal: absent descriptor, past its end, or a direct standalone fetch of any descriptor but the platform one
    always_comb begin
        unique case (FETCH_I.sel)
            SEL_CID: sel_present = cid_present;
            SEL_PLAT: sel_present = plat_present;
            SEL_SSP: sel_present = ssp_present;
            SEL_NONE: sel_present = 1'b0;
        endcase
    end
    assign refuse = !sel_present || ({2'b00, FETCH_I.idx} >= mux_len) ||
        (FETCH_I.direct && FETCH_I.sel != SEL_PLAT);

    // Fetch answer one cycle after the request; a refused byte reads zero
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            valid_reg <= 1'b0;
            miss_reg <= 1'b0;
            last_reg <= 1'b0;
            byte_reg <= 8'h00;
        end else begin
            valid_reg <= FETCH_I.req;
            miss_reg <= FETCH_I.req && refuse;
            last_reg <= FETCH_I.req && !refuse && ({2'b00, FETCH_I.idx} == mux_len - 8'h01);
            byte_reg <= (FETCH_I.req && !refuse) ? mux_byte : 8'h00;
        end
    end
    assign FETCH_VALID_O = valid_reg;
    assign FETCH_MISS_O = miss_reg;
    assign FETCH_LAST_O = last_reg;
    assign FETCH_BYTE_O = byte_reg;

    a_hub_offers_cid: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && FETCH_I.sel == SEL_CID && !FETCH_I.direct &&
        ctrl_reg[CTRL_HUB_BIT] && FETCH_I.idx < 6'h14 |=> FETCH_VALID_O && !FETCH_MISS_O)
        else $error("hub refused its container descriptor");

    a_direct_refused: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && FETCH_I.direct && FETCH_I.sel != SEL_PLAT
        |=> FETCH_MISS_O && FETCH_BYTE_O == 8'h00)
        else $error("direct fetch was served");

    a_cid_uuid_frozen: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        locked |=> $stable(cid_uuid_reg) && cid_present == $past(cid_present))
        else $error("container identity changed after lock");

    a_resv_byte_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && FETCH_I.idx == IDX_RESV |=> FETCH_BYTE_O == 8'h00)
        else $error("reserved byte not zero");

    a_cid_uuid_byte: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && !refuse && FETCH_I.sel == SEL_CID && FETCH_I.idx == 6'h04
        |=> FETCH_BYTE_O == $past(cid_uuid_reg[7:0]))
        else $error("container uuid misplaced");

    a_ssp_cap_type: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && !refuse && FETCH_I.sel == SEL_SSP && FETCH_I.idx == IDX_CAP
        |=> FETCH_BYTE_O == CAP_SSP)
        else $error("wrong capability type byte");

    a_ssp_length: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && !refuse && FETCH_I.sel == SEL_SSP && FETCH_I.idx == IDX_LEN
        |=> FETCH_BYTE_O == 8'h10 + {1'b0, ssac_reg, 2'b00})
        else $error("length byte does not match entries");

    a_attr_resv_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && !refuse && FETCH_I.sel == SEL_SSP && FETCH_I.idx == 6'h05
        |=> FETCH_BYTE_O[7:1] == 7'h00 && FETCH_BYTE_O[0] == $past(ssic_reg[3]))
        else $error("attribute reserved bits set");

    a_func_resv_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && !refuse && FETCH_I.sel == SEL_SSP && FETCH_I.idx == IDX_SSP_FUNC
        |=> FETCH_BYTE_O == {4'h0, $past(min_ssid_reg)})
        else $error("functionality low byte wrong");

    a_plat_tail_end: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && plat_present && FETCH_I.sel == SEL_PLAT && !FETCH_I.direct &&
        FETCH_I.idx == 6'h13 + {2'b00, plat_dlen_reg} |=> FETCH_LAST_O && !FETCH_MISS_O)
        else $error("platform data end misplaced");

    // Both bytes of the reserved word read zero whether served or refused
    a_ssp_resv_word: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && FETCH_I.sel == SEL_SSP && FETCH_I.idx[5:1] == IDX_SSP_RESV[5:1]
        |=> FETCH_BYTE_O == 8'h00)
        else $error("reserved word not zero");

    a_sublink_entry: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        FETCH_I.req && !refuse && FETCH_I.sel == SEL_SSP && FETCH_I.idx == IDX_SUBLINK
        |=> FETCH_BYTE_O == $past(sublink_reg[7:0]))
        else $error("sublink entry misplaced");

endmodule

// ===== verif/capdesc_host_model.sv
`timescale 1ns/100ps
module capdesc_host_model
    import capdesc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Walk command
    input wire logic go_i,
    input wire desc_sel_e sel_i,
    input wire logic direct_i,
    input wire logic [5:0] count_i,
    output logic busy_o,
    // Device fetch port
    output fetch_req_s fetch_o,
    input wire logic valid_i,
    input wire logic miss_i,
    input wire logic last_i,
    input wire logic [7:0] byte_i,
    // Collected answers, one slot per byte index
    output logic [255:0] bytes_o,
    output logic [31:0] miss_o,
    output logic [31:0] last_o,
    output logic [31:0] valid_o
);
    logic run_reg;
    logic wait_reg;
    logic [5:0] idx_reg;
    logic [5:0] cnt_reg;
    logic [5:0] rsp_idx_reg;

    // Walk the indices one per cycle, back to back, past the end if asked
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
            idx_reg <= 6'h00;
            cnt_reg <= 6'h00;
        end else if (go_i && !busy_o) begin
            run_reg <= (count_i != 6'h00);
            idx_reg <= 6'h00;
            cnt_reg <= count_i;
        end else if (run_reg) begin
            idx_reg <= idx_reg + 6'h01;
            run_reg <= ((idx_reg + 6'h01) != cnt_reg);
        end
    end

    // Idle lines carry the inverse of the last select and direct and of the index after the last, so stale values never match
    always_comb begin
        fetch_o.req = run_reg;
        fetch_o.sel = run_reg ? sel_i : desc_sel_e'(~sel_i);
        fetch_o.idx = run_reg ? idx_reg : ~idx_reg;
        fetch_o.direct = run_reg ? direct_i : ~direct_i;
    end

    // Each answer is taken exactly one cycle after its request
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_reg <= 1'b0;
            rsp_idx_reg <= 6'h00;
            bytes_o <= '0;
            miss_o <= '0;
            last_o <= '0;
            valid_o <= '0;
        end else begin
            wait_reg <= run_reg;
            rsp_idx_reg <= idx_reg;
            if (go_i && !busy_o) begin
                bytes_o <= '0;
                miss_o <= '0;
                last_o <= '0;
                valid_o <= '0;
            end else if (wait_reg) begin
                valid_o[rsp_idx_reg[4:0]] <= valid_i;
                miss_o[rsp_idx_reg[4:0]] <= miss_i;
                last_o[rsp_idx_reg[4:0]] <= last_i;
                bytes_o[rsp_idx_reg[4:0] * 8 +: 8] <= byte_i;
            end
        end
    end

    // Busy until the last answer has landed
    assign busy_o = run_reg | wait_reg;
endmodule

// ===== verif/tb_usb_capability_descriptor_rom.sv
`timescale 1ns/100ps
module tb_usb_capability_descriptor_rom
    import capdesc_pkg::*;
;
    localparam logic [7:0] T_DESC = 8'h10;
    localparam logic [7:0] T_CID = 8'h04;
    localparam logic [7:0] T_PLAT = 8'h05;
    localparam logic [7:0] T_SSP = 8'h0A;
    logic clk, rst, wr, rd, go, dir, valid, miss, last, hbusy;
    logic [7:0] addr, fbyte;
    logic [31:0] wdata, rdata, hmiss, hlast, hvalid, seed, w, v;
    logic [5:0] cnt;
    logic [255:0] hbytes;
    desc_sel_e sel;
    fetch_req_s fetch;
    logic [127:0] cid_uuid, plat_uuid, sublink;
    logic [63:0] plat_data;
    logic [4:0] ssac;
    logic [3:0] ssic, ssid, rx, tx;
    int dlen, it, n_errors, comparisons;

    capdesc_rom #(.DESC_TYPE(T_DESC), .CAP_CID(T_CID), .CAP_PLAT(T_PLAT), .CAP_SSP(T_SSP)) u_dut (
        .CLK_SYS_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .FETCH_I(fetch), .FETCH_VALID_O(valid),
        .FETCH_MISS_O(miss), .FETCH_LAST_O(last), .FETCH_BYTE_O(fbyte));
    capdesc_host_model u_host (
        .clk_i(clk), .rst_i(rst), .go_i(go), .sel_i(sel), .direct_i(dir), .count_i(cnt),
        .busy_o(hbusy), .fetch_o(fetch), .valid_i(valid), .miss_i(miss), .last_i(last),
        .byte_i(fbyte), .bytes_o(hbytes), .miss_o(hmiss), .last_o(hlast), .valid_o(hvalid));

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Repeatable pseudo-random source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Descriptor length as the bytes actually sent
    function automatic int exp_len(input desc_sel_e s);
        return (s == SEL_CID) ? 20 : (s == SEL_PLAT) ? 20 + dlen : 16 + 4 * int'(ssac);
    endfunction

    // Expected byte at one offset of a descriptor
    function automatic logic [7:0] exp_byte(input desc_sel_e s, input int i);
        logic [31:0] attr;
        logic [15:0] func;
        attr = {23'h0, ssic, ssac};
        func = {tx, rx, 4'h0, ssid};
        if (i == 0) return 8'(exp_len(s));
        if (i == 1) return T_DESC;
        if (i == 2) return (s == SEL_CID) ? T_CID : (s == SEL_PLAT) ? T_PLAT : T_SSP;
        if (i == 3) return 8'h00;
        if (s != SEL_SSP) begin
            if (i < 20 && s == SEL_CID) return cid_uuid[(i - 4) * 8 +: 8];
            if (i < 20) return plat_uuid[(i - 4) * 8 +: 8];
            return plat_data[(i - 20) * 8 +: 8];
        end
        if (i < 8) return attr[(i - 4) * 8 +: 8];
        if (i < 10) return func[(i - 8) * 8 +: 8];
        if (i < 12) return 8'h00;
        return sublink[(i - 12) * 8 +: 8];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // Register bus cycles; an idle cycle after each keeps strobes from re-asserting in one step
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdata, e, "register read");
    endtask

    task automatic wr_words(input logic [7:0] base, input logic [127:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            reg_wr(base + 8'(4 * i), d[32 * i +: 32]);
        end
    endtask

    // Host walks n offsets; len 0 means every byte must be refused
    task automatic check_walk(input desc_sel_e s, input logic d, input int n, input int len);
        int k;
        sel <= s;
        dir <= d;
        cnt <= 6'(n);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hbusy !== 1'b0 && k < 100);
        chk(32'(k < 100), 32'h1, "walk hung");
        for (int i = 0; i < n; i++) begin
            chk(hvalid[i], 32'h1, "fetch valid");
            chk(hbytes[i * 8 +: 8], (i < len) ? exp_byte(s, i) : 8'h00, "fetch byte");
            chk(hmiss[i], 32'(i >= len), "fetch miss");
            chk(hlast[i], 32'(i == len - 1), "fetch last");
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized well above the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        seed = 32'h00010895;
        rst = 1'b1;
        {wr, rd, go, dir, addr, wdata, cnt} = '0;
        sel = SEL_NONE;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd(OFS_CTRL, 32'h0);
        reg_rd(OFS_STATUS, 32'h0);
        reg_rd(8'h60, 32'h0);
        check_walk(SEL_CID, 1'b0, 4, 0);
        check_walk(SEL_NONE, 1'b0, 2, 0);
        cid_uuid = {rnd(), rnd(), rnd(), rnd()};
        wr_words(OFS_CID_UUID, cid_uuid, 4);
        reg_wr(OFS_CTRL, 32'h11);
        check_walk(SEL_CID, 1'b0, 22, exp_len(SEL_CID));
        reg_wr(OFS_CTRL, 32'h0C);
        wr_words(OFS_CID_UUID, {rnd(), rnd(), rnd(), rnd()}, 4);
        check_walk(SEL_CID, 1'b0, 22, exp_len(SEL_CID));
        check_walk(SEL_CID, 1'b1, 3, 0);
        for (it = 0; it < 3; it++) begin
            plat_uuid = {rnd(), rnd(), rnd(), rnd()};
            plat_data = {rnd(), rnd()};
            dlen = (it == 0) ? 0 : (it == 1) ? 8 : int'(rnd() % 9);
            wr_words(OFS_PLAT_UUID, plat_uuid, 4);
            wr_words(OFS_PLAT_DATA, {64'h0, plat_data}, 2);
            reg_wr(OFS_PLAT_DLEN, 32'(dlen));
            check_walk(SEL_PLAT, it[0], 30, exp_len(SEL_PLAT));
        end
        for (it = 0; it < 4; it++) begin
            w = rnd();
            v = rnd();
            ssac = (it == 0) ? 5'h03 : {3'h0, w[1:0]};
            {tx, rx, ssid, ssic} = w[17:2];
            sublink = {rnd(), rnd(), rnd(), rnd()};
            reg_wr(OFS_SSP_ATTR, {v[31:9], ssic, ssac});
            reg_wr(OFS_SSP_FUNC, {v[31:16], tx, rx, v[7:4], ssid});
            wr_words(OFS_SUBLINK, sublink, 4);
            check_walk(SEL_SSP, 1'b0, 30, exp_len(SEL_SSP));
        end
        check_walk(SEL_SSP, 1'b1, 3, 0);
        w = {4'h0, 3'h7, 1'h1, 8'(exp_len(SEL_SSP)), 8'(exp_len(SEL_PLAT)), 8'h14};
        reg_rd(OFS_STATUS, w);
        wrap_up();
    end
endmodule
